// ==== logic/pcs_pkg.sv ====
// Purpose: Shared constants for the program counter, return stack and indirect path.
// Assumes: Byte addresses on a 32-bit APB; one clock domain.
// Notes:   Field positions and reset values are named here only.
package pcs_pkg;

    // ***********************************************************
    // Widths
    // ***********************************************************
    localparam int PC_W     = 13;
    localparam int PCL_W    = 8;
    localparam int PCU_W    = 5;
    localparam int JMP_W    = 11;
    localparam int SP_W     = 3;
    localparam int STK_DEP  = 8;
    localparam int DA_W     = 9;
    localparam int DIR_W    = 7;

    // ***********************************************************
    // Register byte addresses
    // ***********************************************************
    localparam logic [7:0] ADDR_PC_LOW_BYTE      = 8'h00;
    localparam logic [7:0] ADDR_PC_HIGH_LATCH    = 8'h04;
    localparam logic [7:0] ADDR_INDIRECT_POINTER = 8'h08;
    localparam logic [7:0] ADDR_STATUS_BANK      = 8'h0c;

    // ***********************************************************
    // Field positions and fixed values
    // ***********************************************************
    localparam int LATCH_W      = 5;
    localparam int LATCH_JMP_HI = 4;
    localparam int LATCH_JMP_LO = 3;
    localparam int BANK_BIT     = 7;

    localparam logic [PC_W-1:0]  PC_RESET      = 13'h0000;
    localparam logic [PC_W-1:0]  PC_ONE        = 13'h0001;
    localparam logic [PC_W-1:0]  INT_VECTOR    = 13'h0004;
    localparam logic [DIR_W-1:0] INDIRECT_PORT = 7'h00;
    localparam logic [7:0]       BYTE_ZERO     = 8'h00;
    localparam logic [SP_W-1:0]  SP_ONE        = 3'h1;
    localparam logic [SP_W-1:0]  SP_RESET      = 3'h0;

endpackage

// ==== logic/pcs_stack_mem.sv ====
// Purpose: Eight-entry return stack storage with registered read data.
// Assumes: One write and one read per cycle, same clock.
// Notes:   A write to the entry being read is forwarded to the read register.
`timescale 1ns/1ps
module pcs_stack_mem (
    input  wire logic                              sys_clk,
    input  wire logic                              rstn,
    input  wire logic                              wr_en,
    input  wire logic [pcs_pkg::SP_W-1:0]          wr_idx,
    input  wire logic [pcs_pkg::PC_W-1:0]          wr_data,
    input  wire logic [pcs_pkg::SP_W-1:0]          rd_idx,
    output logic      [pcs_pkg::PC_W-1:0]          rd_data_r
);
    import pcs_pkg::*;

    logic [PC_W-1:0] entry_r [STK_DEP];
    logic [PC_W-1:0] rd_data_nxt;

    // Read select with write-through
    always_comb begin
        if (wr_en && (wr_idx == rd_idx)) begin
            rd_data_nxt = wr_data;
        end else begin
            rd_data_nxt = entry_r[rd_idx];
        end
    end

    // Storage; entries carry no reset, stale values are legal
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            entry_r[wr_idx] <= wr_data;
        end
    end

    // Registered read data
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_r <= PC_RESET;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

endmodule

// ==== logic/pcs_core.sv ====
// Purpose: Program counter, circular return stack and indirect data addressing.
// Assumes: Sequencer inputs are synchronous to sys_clk; APB slave for registers.
// Notes:   All outputs are registered; APB answers with one-cycle access phase.
//
// Summary of operation
// - Program counter is 13 bits; low byte register is readable and writable.
// - Upper five counter bits are hidden; software loads them only through the high latch.
// - Any reset clears the whole program counter.
// - Writing the low byte copies latch bits 4..0 into upper counter bits.
// - Jump and call take top two counter bits from latch bits 4..3.
// - Return stack holds eight 13-bit entries outside program and data space.
// - Stack pointer is internal and cannot be read or written.
// - Calls and interrupt vectoring push the program counter.
// - Return, literal exit and interrupt exit pop into the program counter.
// - Pushes and pops leave the high latch unchanged.
// - Stack is circular: ninth push overwrites the first entry.
// - No overflow or underflow flag exists; wrapping is silent.
// - Indirect port is not storage; it accesses the location the pointer selects.
// - Reading the indirect port through a pointer to itself returns zero.
// - Writing the indirect port through a pointer to itself stores nothing.
// - Indirect address is bank select bit above the eight pointer bits.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module pcs_core (
    input  wire logic                              sys_clk,
    input  wire logic                              rstn,
    // APB slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [7:0]                        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // Instruction sequencer
    input  wire logic                              seq_advance,
    input  wire logic                              seq_direct_jump,
    input  wire logic                              seq_call,
    input  wire logic [pcs_pkg::JMP_W-1:0]         seq_target,
    input  wire logic                              seq_return,
    input  wire logic                              seq_int_vector,
    input  wire logic                              seq_pcl_wr,
    input  wire logic [pcs_pkg::PCL_W-1:0]         seq_pcl_data,
    output logic      [pcs_pkg::PC_W-1:0]          pc_out,
    // Data memory access path
    input  wire logic                              dm_req,
    input  wire logic                              dm_we,
    input  wire logic [pcs_pkg::DA_W-1:0]          dm_addr,
    output logic      [pcs_pkg::DA_W-1:0]          dm_eff_addr,
    output logic                                   dm_eff_re,
    output logic                                   dm_eff_we,
    output logic                                   dm_read_zero
);
    import pcs_pkg::*;

    // ***********************************************************
    // Declarations
    // ***********************************************************
    logic [PC_W-1:0]    pc_r,        pc_nxt;
    logic [LATCH_W-1:0] latch_r,     latch_nxt;
    logic [7:0]         pointer_r,   pointer_nxt;
    logic               bank_r,      bank_nxt;
    logic [SP_W-1:0]    sp_r,        sp_nxt;
    logic [31:0]        prdata_r,    prdata_nxt;
    logic               pready_r,    pready_nxt;
    logic               pslverr_r,   pslverr_nxt;
    logic [DA_W-1:0]    eff_addr_r,  eff_addr_nxt;
    logic               eff_re_r,    eff_re_nxt;
    logic               eff_we_r,    eff_we_nxt;
    logic               rzero_r,     rzero_nxt;

    logic               apb_wr;
    logic               addr_hit;
    logic               push;
    logic               pop;
    logic               pcl_load;
    logic [PCL_W-1:0]   pcl_value;
    logic [PC_W-1:0]    stack_top;
    logic [SP_W-1:0]    rd_idx;
    logic               is_indirect;
    logic               self_point;

    // ***********************************************************
    // Return stack storage
    // ***********************************************************
    // Stack sits outside program and data space
    pcs_stack_mem u_stack (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .wr_en     (push),
        .wr_idx    (sp_r),
        .wr_data   (pc_r),
        .rd_idx    (rd_idx),
        .rd_data_r (stack_top)
    );

    // ***********************************************************
    // APB decode
    // ***********************************************************
    // Write commits only at the completing access edge
    assign apb_wr   = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign addr_hit = (paddr == ADDR_PC_LOW_BYTE) || (paddr == ADDR_PC_HIGH_LATCH) ||
                      (paddr == ADDR_INDIRECT_POINTER) || (paddr == ADDR_STATUS_BANK);

    // Read data, ready and error prepared during setup
    always_comb begin
        pready_nxt  = psel & ~penable;
        pslverr_nxt = psel & ~penable & ~addr_hit;
        prdata_nxt  = prdata_r;
        if (psel && !penable) begin
            prdata_nxt = '0;
            unique case (paddr)
                ADDR_PC_LOW_BYTE:      prdata_nxt[PCL_W-1:0]   = pc_r[PCL_W-1:0];
                ADDR_PC_HIGH_LATCH:    prdata_nxt[LATCH_W-1:0] = latch_r;
                ADDR_INDIRECT_POINTER: prdata_nxt[7:0]         = pointer_r;
                ADDR_STATUS_BANK:      prdata_nxt[BANK_BIT]    = bank_r;
                default:               prdata_nxt              = '0;
            endcase
        end
    end

    // ***********************************************************
    // Program counter and stack control
    // ***********************************************************
    // Low byte load from either the sequencer or the register bus
    assign pcl_load  = seq_pcl_wr | (apb_wr && (paddr == ADDR_PC_LOW_BYTE));
    assign pcl_value = seq_pcl_wr ? seq_pcl_data : pwdata[PCL_W-1:0];

    assign push = seq_int_vector | (seq_call & ~seq_return);
    assign pop  = seq_return & ~seq_int_vector;

    // Read index always tracks the entry below the next pointer
    assign rd_idx = sp_nxt - SP_ONE;

    // Next counter value; interrupt, return, jump, low byte write, advance
    always_comb begin
        pc_nxt = pc_r;
        sp_nxt = sp_r;
        if (seq_int_vector) begin
            pc_nxt = INT_VECTOR;
            sp_nxt = sp_r + SP_ONE;
        end else if (seq_return) begin
            pc_nxt = stack_top;
            sp_nxt = sp_r - SP_ONE;
        end else if (seq_direct_jump || seq_call) begin
            pc_nxt = {latch_r[LATCH_JMP_HI:LATCH_JMP_LO], seq_target};
            if (seq_call) begin
                sp_nxt = sp_r + SP_ONE;
            end
        end else if (pcl_load) begin
            pc_nxt = {latch_r, pcl_value};
        end else if (seq_advance) begin
            pc_nxt = pc_r + PC_ONE;
        end
    end

    // ***********************************************************
    // Software registers
    // ***********************************************************
    // Latch changes only by register write, never by push or pop
    always_comb begin
        latch_nxt   = latch_r;
        pointer_nxt = pointer_r;
        bank_nxt    = bank_r;
        if (apb_wr) begin
            unique case (paddr)
                ADDR_PC_HIGH_LATCH:    latch_nxt   = pwdata[LATCH_W-1:0];
                ADDR_INDIRECT_POINTER: pointer_nxt = pwdata[7:0];
                ADDR_STATUS_BANK:      bank_nxt    = pwdata[BANK_BIT];
                default:               latch_nxt   = latch_r;
            endcase
        end
    end

    // ***********************************************************
    // Indirect data path
    // ***********************************************************
    // Indirect port address redirects through the pointer
    assign is_indirect = (dm_addr[DIR_W-1:0] == INDIRECT_PORT);
    assign self_point  = (pointer_r[DIR_W-1:0] == INDIRECT_PORT);

    always_comb begin
        eff_addr_nxt = dm_addr;
        eff_re_nxt   = dm_req & ~dm_we;
        eff_we_nxt   = dm_req & dm_we;
        rzero_nxt    = 1'b0;
        if (dm_req && is_indirect) begin
            eff_addr_nxt = {bank_r, pointer_r};
            if (self_point) begin
                eff_re_nxt = 1'b0;
                eff_we_nxt = 1'b0;
                rzero_nxt  = ~dm_we;
            end
        end
    end

    // ***********************************************************
    // State registers
    // ***********************************************************
    // Any reset clears the counter and pointer
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pc_r       <= PC_RESET;
            sp_r       <= SP_RESET;
            latch_r    <= '0;
            pointer_r  <= BYTE_ZERO;
            bank_r     <= 1'b0;
            prdata_r   <= '0;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            eff_addr_r <= '0;
            eff_re_r   <= 1'b0;
            eff_we_r   <= 1'b0;
            rzero_r    <= 1'b0;
        end else begin
            pc_r       <= pc_nxt;
            sp_r       <= sp_nxt;
            latch_r    <= latch_nxt;
            pointer_r  <= pointer_nxt;
            bank_r     <= bank_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            eff_addr_r <= eff_addr_nxt;
            eff_re_r   <= eff_re_nxt;
            eff_we_r   <= eff_we_nxt;
            rzero_r    <= rzero_nxt;
        end
    end

    // Outputs straight from flops
    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign pc_out       = pc_r;
    assign dm_eff_addr  = eff_addr_r;
    assign dm_eff_re    = eff_re_r;
    assign dm_eff_we    = eff_we_r;
    assign dm_read_zero = rzero_r;

endmodule

// ==== verif/pcs_core_properties.sv ====
// Purpose: Concurrent checks on program counter, return stack and indirect path
// Assumes: Bound into pcs_core; one clock, reset active low
// Notes:   Shadow latch, pointer and bank follow committed APB writes
`timescale 1ns/1ps
module pcs_core_properties (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        seq_advance,
    input wire logic        seq_direct_jump,
    input wire logic        seq_call,
    input wire logic [10:0] seq_target,
    input wire logic        seq_return,
    input wire logic        seq_int_vector,
    input wire logic        seq_pcl_wr,
    input wire logic [7:0]  seq_pcl_data,
    input wire logic [12:0] pc_out,
    input wire logic        dm_req,
    input wire logic        dm_we,
    input wire logic [8:0]  dm_addr,
    input wire logic [8:0]  dm_eff_addr,
    input wire logic        dm_eff_re,
    input wire logic        dm_eff_we,
    input wire logic        dm_read_zero
);
    import pcs_pkg::*;
    logic [4:0] lat_r;
    logic [7:0] ptr_r;
    logic       bnk_r, wr_ok, hi_op, ind;
    // **********************************************
    // Shadow state and assertions
    // **********************************************
    assign wr_ok = psel && penable && pready && pwrite;
    assign hi_op = seq_int_vector || seq_return || seq_direct_jump || seq_call;
    assign ind   = dm_req && (dm_addr[6:0] == INDIRECT_PORT);
    // Shadow copies of software-written registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lat_r <= '0;
            ptr_r <= '0;
            bnk_r <= 1'b0;
        end else if (wr_ok) begin
            if (paddr == ADDR_PC_HIGH_LATCH) lat_r <= pwdata[4:0];
            if (paddr == ADDR_INDIRECT_POINTER) ptr_r <= pwdata[7:0];
            if (paddr == ADDR_STATUS_BANK) bnk_r <= pwdata[BANK_BIT];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_reset_clear: assert property ($rose(rstn) |-> pc_out == PC_RESET)
        else $error("pc not zero after reset");
    a_pc_advance: assert property (seq_advance && !hi_op && !seq_pcl_wr
        && !(wr_ok && paddr == ADDR_PC_LOW_BYTE) |=> pc_out == $past(pc_out) + PC_ONE)
        else $error("pc did not step by one");
    a_jump_load: assert property ((seq_direct_jump || seq_call) && !seq_int_vector
        && !seq_return |=> pc_out == {lat_r[4:3], $past(seq_target)})
        else $error("jump target wrong");
    a_low_write: assert property (seq_pcl_wr && !hi_op
        |=> pc_out == {lat_r, $past(seq_pcl_data)})
        else $error("low byte write load wrong");
    a_int_vector: assert property (seq_int_vector |=> pc_out == INT_VECTOR)
        else $error("vector not taken");
    a_call_return: assert property (seq_call && !seq_int_vector && !seq_return
        ##1 seq_return && !seq_int_vector |=> pc_out == $past(pc_out, 2))
        else $error("return address wrong");
    a_apb_answer: assert property (psel && !penable |=> pready && penable)
        else $error("no answer in access phase");
    a_indirect_path: assert property (ind && ptr_r[6:0] != INDIRECT_PORT
        |=> dm_eff_addr == {bnk_r, ptr_r} && dm_eff_re == !$past(dm_we)
        && dm_eff_we == $past(dm_we))
        else $error("indirect address wrong");
    a_self_point: assert property (ind && ptr_r[6:0] == INDIRECT_PORT
        |=> !dm_eff_re && !dm_eff_we && dm_read_zero == !$past(dm_we))
        else $error("self pointing access reached memory");
    // Main scenarios seen
    c_call_ret: cover property (seq_call ##1 seq_return);
    c_self_read: cover property (ind ##1 dm_read_zero);
    c_vector: cover property (seq_int_vector);
endmodule
bind pcs_core pcs_core_properties i_pcs_core_properties (.*);

// ==== verif/pcs_dmem_model.sv ====
// Purpose: Data memory side model counting stores that reach storage
// Assumes: Store strobes are registered one-cycle pulses
// Notes:   Only effective addresses ever reach this side
`timescale 1ns/1ps
module pcs_dmem_model (
    input  wire logic sys_clk,
    input  wire logic dm_eff_we,
    output int        n_wr
);
    // Count each store strobe seen at a rising edge
    initial n_wr = 0;
    always @(posedge sys_clk) if (dm_eff_we) n_wr++;
endmodule

// ==== verif/pcs_core_tb.sv ====
// Purpose: Self-checking bench for program counter, stack and indirect path
// Assumes: APB master and sequencer pulses driven at rising edges
// Notes:   Expected stack contents come from a small model in the bench
`timescale 1ns/1ps
module pcs_core_tb;
    import pcs_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, dm_req = 1'b0, dm_we = 1'b0, rd_err;
    logic [7:0] paddr = '0, seq_pcl_data = '0;
    logic [31:0] pwdata = '0, prdata, rd_q;
    logic [5:0] op = '0;
    wire seq_int_vector, seq_return, seq_call, seq_direct_jump, seq_pcl_wr, seq_advance;
    logic [10:0] seq_target = '0;
    logic [12:0] pc_out, pe, stk [8];
    logic [8:0] dm_addr = '0, dm_eff_addr;
    logic dm_eff_re, dm_eff_we, dm_read_zero;
    logic [2:0] sp;
    int n_mismatch = 0, total_checks = 0, n_wr;
    assign {seq_int_vector, seq_return, seq_call, seq_direct_jump, seq_pcl_wr, seq_advance} = op;
    pcs_core i_pcs_core (.*);
    pcs_dmem_model i_pcs_dmem_model (.sys_clk(sys_clk), .dm_eff_we(dm_eff_we), .n_wr(n_wr));
    // Clock
    always #4 sys_clk = ~sys_clk;
    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        // Hold the request until pready is sampled high at a rising edge
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_q = prdata;
        rd_err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 50) n_mismatch++;
    endtask
    // One-cycle sequencer pulse
    task automatic sq(input logic [5:0] k, input logic [10:0] t, input logic [7:0] d);
        @(posedge sys_clk);
        {op, seq_target, seq_pcl_data} <= {k, t, d};
        @(posedge sys_clk);
        op <= 6'h00;
        @(negedge sys_clk);
    endtask
    // One data access request
    task automatic dm(input logic w, input logic [8:0] a);
        @(posedge sys_clk);
        {dm_req, dm_we, dm_addr} <= {1'b1, w, a};
        @(posedge sys_clk);
        dm_req <= 1'b0;
        @(negedge sys_clk);
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        test_done();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        chk(pc_out, PC_RESET);
        for (int a = 0; a < 5; a++) begin
            apb(1'b0, 8'(a * 4), '0);
            chk(rd_q, '0);
            chk(rd_err, a == 4);
        end
        apb(1'b1, ADDR_PC_HIGH_LATCH, 32'h15);
        sq(6'h02, '0, 8'h3c);
        chk(pc_out, 13'h153c);
        apb(1'b0, ADDR_PC_LOW_BYTE, '0);
        chk(rd_q, 32'h3c);
        apb(1'b1, ADDR_PC_LOW_BYTE, 32'h77);
        @(negedge sys_clk);
        chk(pc_out, 13'h1577);
        sq(6'h04, 11'h123, '0);
        chk(pc_out, 13'h1123);
        sq(6'h01, '0, '0);
        chk(pc_out, 13'h1124);
        // Ten pushes wrap the eight-entry stack, nine pops underflow it
        pe = 13'h1124;
        sp = 3'h0;
        for (int i = 0; i < 10; i++) begin
            stk[sp] = pe;
            sp++;
            if (i == 3) begin
                sq(6'h20, '0, '0);
                pe = INT_VECTOR;
            end else begin
                sq(6'h08, 11'(i * 16 + 1), '0);
                pe = {2'b10, 11'(i * 16 + 1)};
            end
            chk(pc_out, pe);
        end
        for (int i = 0; i < 9; i++) begin
            sp--;
            sq(6'h10, '0, '0);
            chk(pc_out, stk[sp]);
        end
        apb(1'b0, ADDR_PC_HIGH_LATCH, '0);
        chk(rd_q, 32'h15);
        // Call then return on the very next edge
        pe = pc_out;
        @(posedge sys_clk);
        op <= 6'h08;
        @(posedge sys_clk);
        op <= 6'h10;
        @(posedge sys_clk);
        op <= 6'h00;
        @(negedge sys_clk);
        chk(pc_out, pe);
        // Indirect accesses, then a pointer aimed at the port itself
        apb(1'b1, ADDR_INDIRECT_POINTER, 32'h25);
        apb(1'b1, ADDR_STATUS_BANK, 32'h80);
        dm(1'b0, 9'h000);
        chk({dm_eff_re, dm_eff_we, dm_read_zero, dm_eff_addr}, {3'b100, 9'h125});
        dm(1'b1, 9'h080);
        chk({dm_eff_re, dm_eff_we, dm_read_zero, dm_eff_addr}, {3'b010, 9'h125});
        dm(1'b0, 9'h031);
        chk({dm_eff_re, dm_eff_we, dm_read_zero, dm_eff_addr}, {3'b100, 9'h031});
        apb(1'b1, ADDR_INDIRECT_POINTER, 32'h80);
        dm(1'b0, 9'h100);
        chk({dm_eff_re, dm_eff_we, dm_read_zero}, 3'b001);
        dm(1'b1, 9'h000);
        chk({dm_eff_re, dm_eff_we, dm_read_zero}, 3'b000);
        repeat (2) @(negedge sys_clk);
        chk(n_wr, 1);
        test_done();
    end
endmodule
